// File: hw/tsr_pair_buf.sv
// small shift buffer with valid and ready on both sides
// assumes a single clock and a synchronous active-high reset
module tsr_pair_buf #(
    parameter int W     = 9,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // filling side
    input  wire logic         s_valid_i,
    output logic              s_ready_o,
    input  wire logic [W-1:0] s_data_i,
    // draining side
    output logic              m_valid_o,
    input  wire logic         m_ready_i,
    output logic [W-1:0]      m_data_o
);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] ent;
        logic [CW-1:0]           cnt;
        logic                    vld;
    } tsr_buf_type;

    tsr_buf_type r;
    tsr_buf_type n;
    logic        pop;
    logic        push;

    // full only when every entry holds a word, so the source really stalls
    assign s_ready_o = (r.cnt != CW'(DEPTH));
    assign pop       = r.vld && m_ready_i;
    assign push      = s_valid_i && s_ready_o;
    assign m_valid_o = r.vld;
    assign m_data_o  = r.ent[0];

    // head always sits in entry 0 so the output is a plain flop
    always_comb begin
        n = r;
        if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                n.ent[i] = r.ent[i+1];
            end
        end
        if (push) begin
            n.ent[r.cnt - CW'(pop)] = s_data_i;
        end
        n.cnt = r.cnt + CW'(push) - CW'(pop);
        n.vld = (n.cnt != '0);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule // tsr_pair_buf

// File: hw/tsr_pkg.sv
// constants shared by the tunnel section reassembler and its register file
// assumes a 32-bit classic wishbone slave port and a byte-wide datagram stream
package tsr_pkg;
    // section and header geometry
    localparam int          SEC_MAX     = 4096;   // largest section the sender may deliver
    localparam int          OFF_W       = 13;     // holds 0..SEC_MAX
    localparam int          NSLOT       = 4;      // concurrent segmented sections
    localparam logic [2:0]  WHOLE_SLOT  = 3'h4;   // extra buffer for unsegmented sections
    localparam int          KEY_W       = 112;    // two addresses, two ports, section tag
    localparam logic [7:0]  HDR_MARKER  = 8'hFF;
    localparam logic [2:0]  HDR_VERSION = 3'h1;
    localparam logic [1:0]  HDR_LAST    = 2'h3;   // index of the fourth header byte
    // header field positions inside the 32-bit header word
    localparam int          MARK_POS    = 24;
    localparam int          VER_POS     = 21;
    localparam int          FIN_POS     = 20;
    localparam int          PIECE_POS   = 16;
    // register map, byte addresses
    localparam logic [7:0]  REG_CTRL    = 8'h00;
    localparam logic [7:0]  REG_STATUS  = 8'h04;
    localparam logic [7:0]  REG_OK_CNT  = 8'h08;
    localparam logic [7:0]  REG_DROP_CNT = 8'h0C;
    localparam int          CTRL_EN_BIT = 0;
    localparam logic        CTRL_EN_RST = 1'b1;
    localparam int          CNT_W       = 16;
    localparam int          STATE_POS   = 8;      // status: receive state field
    // receive sequencer states
    typedef enum logic [1:0] {
        S_HDR,
        S_BODY,
        S_DROP,
        S_DRAIN
    } tsr_st_type;
endpackage

// File: hw/tsr_reassembler.sv
// receive side of broadcast tunnel section delivery: header check and reassembly
// assumes udp payload bytes arrive one per beat with the datagram's 4-tuple held
// steady on the side ports, and that in_last_i marks each datagram's final byte

// What this block does
// - header: marker 0xff, version, final flag, piece index, 16-bit section tag
// - header version field must hold one
// - final flag marks the last segment of the tagged section
// - piece zero starts a section; piece zero with final flag is whole
// - segments match only on both addresses, both ports and section tag
// - receiver rebuilds each segmented section before passing it on
// - four segmented sections are rebuilt at once without loss
module tsr_reassembler import tsr_pkg::*; (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // classic wishbone slave
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [7:0]       wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic [31:0]           wb_dat_o,
    output logic                  wb_ack_o,
    // udp payload stream in
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [7:0]       in_data_i,
    input  wire logic             in_last_i,
    input  wire logic [31:0]      src_ip_i,
    input  wire logic [15:0]      src_port_i,
    input  wire logic [31:0]      dst_ip_i,
    input  wire logic [15:0]      dst_port_i,
    // complete sections out
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [7:0]            out_data_o,
    output logic                  out_last_o
);
    typedef struct packed {
        tsr_st_type                    st;
        logic                          in_ready;
        logic [1:0]                    hdr_cnt;
        logic [23:0]                   hdr;
        logic [2:0]                    cur_slot;
        logic                          fin;
        logic [OFF_W-1:0]              wr_off;
        logic [OFF_W-1:0]              rd_off;
        logic [NSLOT-1:0]              busy;
        logic [NSLOT-1:0][KEY_W-1:0]   key;
        logic [NSLOT-1:0][3:0]         nxt_piece;
        logic [NSLOT:0][OFF_W-1:0]     len;
        logic [CNT_W-1:0]              cnt_ok;
        logic [CNT_W-1:0]              cnt_drop;
        logic                          en;
        logic                          ack;
        logic [31:0]                   rdat;
    } tsr_state_type;
    tsr_state_type   r;
    tsr_state_type   n;
    logic [7:0]      mem [0:(NSLOT+1)*SEC_MAX-1];
    logic            acc;
    logic [31:0]     hw;
    logic [3:0]      piece;
    logic            fin_b;
    logic [KEY_W-1:0] cur_key;
    logic            hdr_done;
    logic            hdr_ok;
    logic            hit;
    logic [1:0]      hit_idx;
    logic            free;
    logic [1:0]      free_idx;
    logic            wr_en;
    logic            push;
    logic            last_rd;
    logic            buf_ready;
    // header word as it completes with the current byte
    assign acc      = in_valid_i && in_ready_o;
    assign hw       = {r.hdr, in_data_i};
    assign piece    = hw[PIECE_POS +: 4];
    assign fin_b    = hw[FIN_POS];
    assign cur_key  = {src_ip_i, src_port_i, dst_ip_i, dst_port_i, hw[15:0]};
    assign hdr_done = (r.st == S_HDR) && acc && (r.hdr_cnt == HDR_LAST) && !in_last_i;
    assign hdr_ok   = r.en && (hw[MARK_POS +: 8] == HDR_MARKER)
                   && (hw[VER_POS +: 3] == HDR_VERSION);
    assign last_rd  = (r.rd_off == r.len[r.cur_slot] - OFF_W'(1));
    assign in_ready_o = r.in_ready;
    assign wb_ack_o   = r.ack;
    assign wb_dat_o   = r.rdat;
    // look up the stream among live slots, and the first free slot
    always_comb begin
        hit      = 1'b0;
        hit_idx  = 2'h0;
        free     = 1'b0;
        free_idx = 2'h0;
        for (int i = NSLOT - 1; i >= 0; i--) begin
            if (r.busy[i] && (r.key[i] == cur_key)) begin
                hit     = 1'b1;
                hit_idx = 2'(i);
            end
            if (!r.busy[i]) begin
                free     = 1'b1;
                free_idx = 2'(i);
            end
        end
    end
    // sequencer, slot table and register file
    always_comb begin
        n     = r;
        wr_en = 1'b0;
        push  = 1'b0;
        // one wait state; write lands at the edge where the master sees ack
        n.ack = wb_cyc_i && wb_stb_i && !r.ack;
        if (wb_cyc_i && wb_stb_i && wb_we_i && r.ack && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
            n.en = wb_dat_i[CTRL_EN_BIT];
        end
        unique case (wb_adr_i)
            REG_CTRL:     n.rdat = {31'h0, r.en};
            REG_STATUS:   n.rdat = {22'h0, r.st, 4'h0, r.busy};
            REG_OK_CNT:   n.rdat = {16'h0, r.cnt_ok};
            REG_DROP_CNT: n.rdat = {16'h0, r.cnt_drop};
            default:      n.rdat = 32'h0;
        endcase
        unique case (r.st)
            S_HDR: begin
                if (acc) begin
                    n.hdr     = hw[23:0];
                    n.hdr_cnt = r.hdr_cnt + 2'h1;
                    if (in_last_i) begin
                        // datagram too short to carry a header and a byte
                        n.hdr_cnt  = 2'h0;
                        n.cnt_drop = r.cnt_drop + CNT_W'(1);
                    end else if (r.hdr_cnt == HDR_LAST) begin
                        n.st     = S_BODY;
                        n.fin    = fin_b;
                        n.wr_off = '0;
                        if (!hdr_ok) begin
                            n.st       = S_DROP;
                            n.cnt_drop = r.cnt_drop + CNT_W'(1);
                        end else if (piece == 4'h0 && fin_b) begin
                            n.cur_slot = WHOLE_SLOT;
                        end else if (piece == 4'h0) begin
                            // a fresh first piece on a live stream restarts that slot
                            if (hit) begin
                                n.cur_slot = {1'b0, hit_idx};
                                n.nxt_piece[hit_idx] = 4'h1;
                            end else if (free) begin
                                n.cur_slot = {1'b0, free_idx};
                                n.busy[free_idx]      = 1'b1;
                                n.key[free_idx]       = cur_key;
                                n.nxt_piece[free_idx] = 4'h1;
                            end else begin
                                // a fifth stream exceeds what the sender promises
                                n.st       = S_DROP;
                                n.cnt_drop = r.cnt_drop + CNT_W'(1);
                            end
                        end else if (hit && r.nxt_piece[hit_idx] == piece) begin
                            n.cur_slot = {1'b0, hit_idx};
                            n.wr_off   = r.len[hit_idx];
                            n.nxt_piece[hit_idx] = piece + 4'h1;
                        end else begin
                            n.st       = S_DROP;
                            n.cnt_drop = r.cnt_drop + CNT_W'(1);
                            if (hit) begin
                                n.busy[hit_idx] = 1'b0;
                            end
                        end
                    end
                end
            end
            S_BODY: begin
                if (acc) begin
                    if (r.wr_off == OFF_W'(SEC_MAX)) begin
                        // oversize: abandon rather than wrap onto the first byte of its own slot
                        n.st       = in_last_i ? S_HDR : S_DROP;
                        n.cnt_drop = r.cnt_drop + CNT_W'(1);
                        if (r.cur_slot != WHOLE_SLOT) begin
                            n.busy[r.cur_slot[1:0]] = 1'b0;
                        end
                    end else begin
                        wr_en    = 1'b1;
                        n.wr_off = r.wr_off + OFF_W'(1);
                        if (in_last_i) begin
                            n.len[r.cur_slot] = r.wr_off + OFF_W'(1);
                            n.st     = r.fin ? S_DRAIN : S_HDR;
                            n.rd_off = '0;
                        end
                    end
                end
            end
            S_DROP: begin
                if (acc && in_last_i) begin
                    n.st = S_HDR;
                end
            end
            S_DRAIN: begin
                push = buf_ready;
                if (push) begin
                    n.rd_off = r.rd_off + OFF_W'(1);
                    if (last_rd) begin
                        n.st     = S_HDR;
                        n.cnt_ok = r.cnt_ok + CNT_W'(1);
                        if (r.cur_slot != WHOLE_SLOT) begin
                            n.busy[r.cur_slot[1:0]] = 1'b0;
                        end
                    end
                end
            end
        endcase
        // input stalls only while a finished section is copied out
        n.in_ready = (n.st != S_DRAIN);
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r          <= '0;
            r.en       <= CTRL_EN_RST;
            r.in_ready <= 1'b1;
        end else begin
            r <= n;
        end
    end
    // section store, one 4096-byte region per slot
    always_ff @(posedge clk_i) begin
        if (wr_en) begin
            mem[{r.cur_slot, r.wr_off[11:0]}] <= in_data_i;
        end
    end
    // output buffer so a stalled receiver loses no byte
    tsr_pair_buf #(
        .W     (9),
        .DEPTH (2)
    ) u_buf (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .s_valid_i (push),
        .s_ready_o (buf_ready),
        .s_data_i  ({last_rd, mem[{r.cur_slot, r.rd_off[11:0]}]}),
        .m_valid_o (out_valid_o),
        .m_ready_i (out_ready_i),
        .m_data_o  ({out_last_o, out_data_o})
    );

    // checks on the sequencer
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_marker;
        hdr_done && hw[MARK_POS +: 8] != HDR_MARKER |=> r.st == S_DROP ##1 !wr_en;
    endproperty
    a_marker: assert property (p_marker) else $error("bad marker not dropped");
    property p_version;
        hdr_done && hw[MARK_POS +: 8] == HDR_MARKER && hw[VER_POS +: 3] != HDR_VERSION |=> r.st == S_DROP;
    endproperty
    a_version: assert property (p_version) else $error("bad version not dropped");
    property p_final;
        r.st == S_BODY && acc && in_last_i && r.fin && r.wr_off != OFF_W'(SEC_MAX)
            |=> r.st == S_DRAIN && !in_ready_o;
    endproperty
    a_final: assert property (p_final) else $error("final piece did not start delivery");
    property p_whole;
        hdr_done && hdr_ok && piece == 4'h0 && fin_b |=> r.cur_slot == WHOLE_SLOT && r.st == S_BODY;
    endproperty
    a_whole: assert property (p_whole) else $error("whole section not routed to its buffer");
    property p_nomatch;
        hdr_done && hdr_ok && piece != 4'h0 && !hit |=> r.st == S_DROP;
    endproperty
    a_nomatch: assert property (p_nomatch) else $error("unmatched segment accepted");
    property p_drain;
        r.st == S_DRAIN && push && last_rd |=> r.st == S_HDR && in_ready_o && out_valid_o;
    endproperty
    a_drain: assert property (p_drain) else $error("delivery did not end cleanly");
    property p_alloc;
        hdr_done && hdr_ok && piece == 4'h0 && !fin_b && !hit && free
            |=> r.cur_slot == {1'b0, $past(free_idx)} && r.busy[$past(free_idx)];
    endproperty
    a_alloc: assert property (p_alloc) else $error("free slot not claimed");
    property p_skip;
        hdr_done && hdr_ok && piece != 4'h0 && hit && r.nxt_piece[hit_idx] != piece
            |=> r.st == S_DROP && !r.busy[$past(hit_idx)];
    endproperty
    a_skip: assert property (p_skip) else $error("out of order piece not abandoned");
    c_whole: cover property (hdr_done && hdr_ok && piece == 4'h0 && fin_b);
    c_join:  cover property (hdr_done && hdr_ok && piece != 4'h0 && hit && r.nxt_piece[hit_idx] == piece);
    c_stall: cover property (out_valid_o && !out_ready_i && !buf_ready);
    c_full:  cover property (r.busy == 4'hF);
endmodule // tsr_reassembler

// File: verification/tsr_headend_model.sv
// headend encapsulator model: plays whole udp payloads into the reassembler
// assumes the bench calls send right after a rising edge of clk_i
module tsr_headend_model (
    // clock
    input  wire logic        clk_i,
    // udp payload stream and its 4-tuple
    output logic             in_valid_o,
    input  wire logic        in_ready_i,
    output logic [7:0]       in_data_o,
    output logic             in_last_o,
    output logic [95:0]      tuple_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle at time zero
    initial begin
        in_valid_o = 1'b0;
        in_data_o  = 8'hA5;
        in_last_o  = 1'b0;
        tuple_o    = '0;
    end

    // one datagram, one section or segment, header already in front
    task automatic send(input logic [7:0] q[$], input logic [95:0] tup, output bit ok);
        int n;
        ok = 1'b1;
        tuple_o <= tup;
        foreach (q[i]) begin
            in_valid_o <= 1'b1;
            in_data_o  <= q[i];
            in_last_o  <= (i == q.size() - 1);
            n = 0;
            // byte held until the edge that sees ready
            do begin
                @(posedge clk_i);
                n++;
            end while (in_ready_i !== 1'b1 && n < 20000);
            if (n >= 20000) ok = 1'b0;
        end
        in_valid_o <= 1'b0;
        in_last_o  <= 1'b0;
        in_data_o  <= ~in_data_o;  // released lines carry no stale byte
        tuple_o    <= ~tup;
        @(posedge clk_i);
    endtask
endmodule  // tsr_headend_model

// File: verification/tsr_reassembler_bench.sv
// self-checking bench for the tunnel section reassembler
// assumes tsr_pkg and the headend model; expected bytes come from a queue model
module tsr_reassembler_bench import tsr_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [95:0] BASE = 96'h0A00_0001_1F90_EF01_0203_4E20;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]  wb_adr_i, in_data_i, out_data_o;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        in_valid_i, in_ready_o, in_last_i, out_valid_o, out_ready_i, out_last_o;
    logic [95:0] tuple;
    int          seed = 9;
    int          miscompares = 0;
    int          num_checks = 0;
    int          oks = 0;
    int          drops = 0;
    bit          en = 1'b1;
    // queue model: four reassembly slots and the expected {last, byte} stream
    logic [111:0] slot_key[4];
    bit           slot_live[4];
    int           slot_next[4];
    logic [7:0]   slot_data[4][$];
    logic [8:0]   expq[$];

    tsr_reassembler tsr_reassembler_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .in_valid_i(in_valid_i), .in_ready_o(in_ready_o), .in_data_i(in_data_i),
        .in_last_i(in_last_i), .src_ip_i(tuple[95:64]), .src_port_i(tuple[63:48]), .dst_ip_i(tuple[47:16]),
        .dst_port_i(tuple[15:0]), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
        .out_data_o(out_data_o), .out_last_o(out_last_o));
    tsr_headend_model tsr_headend_model_i (.clk_i(clk_i), .in_valid_o(in_valid_i), .in_ready_i(in_ready_o),
        .in_data_o(in_data_i), .in_last_o(in_last_i), .tuple_o(tuple));

    // 200 MHz
    always #2.5 clk_i = ~clk_i;

    task automatic results();
        if (miscompares == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // sink with random stalls; the buffer must lose nothing while stalled
    always @(posedge clk_i) begin
        if (!rst_i && out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
            num_checks++;
            if (expq.size() == 0 || {out_last_o, out_data_o} !== expq[0]) begin
                miscompares++;
                $display("[FAIL] out byte expected %h seen %h", expq[0], {out_last_o, out_data_o});
            end
            if (expq.size() > 0) void'(expq.pop_front());
        end
        out_ready_i <= ($random(seed) & 3) != 0;
    end

    // classic single cycle; held until ack is sampled
    task automatic wb(input bit we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        wb_sel_i <= 4'hF;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 100);
        rd = wb_dat_o;
        if (n >= 100) begin
            miscompares++;
            $display("[FAIL] wb ack expected 1 seen %b", wb_ack_o);
            results();
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp, input string nm);
        logic [31:0] d;
        wb(1'b0, adr, 32'h0, d);
        num_checks++;
        if (d !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, d);
        end
    endtask

    function automatic logic [95:0] tup_of(input int k);
        int sh[5] = '{0, 0, 64, 48, 16};
        return (k > 1) ? BASE ^ (96'h1 << sh[k]) : BASE;
    endfunction

    // builds one datagram, predicts its fate, then hands it to the headend
    task automatic dgram(input logic [95:0] tup, input logic [7:0] mk, input logic [2:0] ver, input bit fin,
                         input logic [3:0] pc, input logic [15:0] tag, input int len);
        logic [7:0] q[$];
        int s;
        bit ok;
        q = '{mk, {ver, fin, pc}, tag[15:8], tag[7:0]};
        repeat (len) q.push_back(8'($random(seed)));
        s = -1;
        for (int i = 0; i < NSLOT; i++) if (slot_live[i] && slot_key[i] === {tup, tag}) s = i;
        if (mk !== HDR_MARKER || ver !== HDR_VERSION || !en || len == 0) begin
            drops++;
        end else if (pc == 0 && fin) begin
            for (int i = 4; i < q.size(); i++) expq.push_back({i == q.size() - 1, q[i]});
            oks++;
        end else if (pc == 0) begin
            for (int i = NSLOT - 1; i >= 0; i--) if (s < 0 && !slot_live[i]) s = i;
            for (int i = NSLOT - 1; i >= 0; i--) if (slot_live[i] && slot_key[i] === {tup, tag}) s = i;
            if (s < 0) drops++;
            else begin
                slot_live[s] = 1'b1;
                slot_key[s]  = {tup, tag};
                slot_next[s] = 1;
                slot_data[s] = q[4:$];
            end
        end else if (s < 0 || slot_next[s] != pc) begin
            drops++;
            if (s >= 0) slot_live[s] = 1'b0;
        end else begin
            foreach (q[i]) if (i > 3) slot_data[s].push_back(q[i]);
            slot_next[s]++;
            if (slot_data[s].size() > SEC_MAX) begin
                drops++;
                slot_live[s] = 1'b0;
            end else if (fin) begin
                for (int i = 0; i < slot_data[s].size(); i++)
                    expq.push_back({i == slot_data[s].size() - 1, slot_data[s][i]});
                oks++;
                slot_live[s] = 1'b0;
            end
        end
        tsr_headend_model_i.send(q, tup, ok);
        if (!ok) begin
            miscompares++;
            $display("[FAIL] in_ready expected 1 seen 0");
            results();
        end
    endtask

    initial begin
        logic [31:0] d;
        int n;
        clk_i = 1'b0;
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0;
        out_ready_i = 1'b1;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // reset values, then an unmapped place that must read zero
        rd_chk(REG_CTRL, 32'h1, "ctrl");
        rd_chk(REG_STATUS, 32'h0, "status");
        wb(1'b1, 8'h10, 32'hFFFF_FFFF, d);
        rd_chk(8'h10, 32'h0, "unmapped");
        // whole sections of random size, then bad marker, version, empty body
        repeat (6) dgram(BASE, 8'hFF, 3'h1, 1'b1, 4'h0, 16'($random(seed)), 1 + ($random(seed) & 63));
        dgram(BASE, 8'hFE, 3'h1, 1'b1, 4'h0, 16'h0002, 8);
        dgram(BASE, 8'hFF, 3'h2, 1'b1, 4'h0, 16'h0003, 8);
        dgram(BASE, 8'hFF, 3'h1, 1'b1, 4'h0, 16'h0004, 0);
        // four streams at once, keys differing in one field; a fifth finds all slots busy
        for (int p = 0; p < 3; p++)
            for (int k = 0; k < 5; k++)
                dgram(tup_of(k), 8'hFF, 3'h1, p == 2, 4'(p), 16'h0100 + 16'(k == 1), 24 + k);
        // skipped piece, repeated piece, restart on piece zero
        dgram(BASE ^ 96'h1, 8'hFF, 3'h1, 1'b0, 4'h0, 16'h0007, 10);
        dgram(BASE ^ 96'h1, 8'hFF, 3'h1, 1'b0, 4'h2, 16'h0007, 10);
        dgram(BASE ^ 96'h1, 8'hFF, 3'h1, 1'b1, 4'h1, 16'h0007, 10);
        for (int r = 0; r < 3; r++) dgram(BASE ^ 96'h1, 8'hFF, 3'h1, 1'b0, 4'(r > 0), 16'h0008, 10);
        dgram(BASE ^ 96'h1, 8'hFF, 3'h1, 1'b1, 4'h2, 16'h0008, 10);
        dgram(BASE, 8'hFF, 3'h1, 1'b0, 4'h0, 16'h0009, 10);
        dgram(BASE, 8'hFF, 3'h1, 1'b0, 4'h0, 16'h0009, 12);
        dgram(BASE, 8'hFF, 3'h1, 1'b1, 4'h1, 16'h0009, 5);
        // section of exactly the largest size, then one byte more
        for (int b = 0; b < 2; b++) begin
            dgram(BASE, 8'hFF, 3'h1, 1'b0, 4'h0, 16'(10 + b), 2000);
            dgram(BASE, 8'hFF, 3'h1, 1'b0, 4'h1, 16'(10 + b), 2000);
            dgram(BASE, 8'hFF, 3'h1, 1'b1, 4'h2, 16'(10 + b), 96 + b);
        end
        // disabled receiver drops and counts
        wb(1'b1, REG_CTRL, 32'h0, d);
        en = 1'b0;
        rd_chk(REG_CTRL, 32'h0, "ctrl off");
        dgram(BASE, 8'hFF, 3'h1, 1'b1, 4'h0, 16'h0005, 4);
        wb(1'b1, REG_CTRL, 32'h1, d);
        en = 1'b1;
        n = 0;
        while (expq.size() > 0 && n < 20000) begin
            @(posedge clk_i);
            n++;
        end
        if (expq.size() > 0) begin
            miscompares++;
            $display("[FAIL] pending bytes expected 0 seen %0d", expq.size());
        end
        rd_chk(REG_OK_CNT, 32'(oks), "ok count");
        rd_chk(REG_DROP_CNT, 32'(drops), "drop count");
        results();
    end
endmodule  // tsr_reassembler_bench
